/* File: hw/wbs_pkg.sv */
// Shared types and constants of the bus slave for single and block cycles.
// Assumes one synchronous clock domain shared by master and slave.
package wbs_pkg;

    // Default widths of the bus and of the backing store, and the width of the wait-state count
    localparam int WBS_ADR_W_DEF = 32;  // Address bus width
    localparam int WBS_DAT_W_DEF = 16;  // Data bus width
    localparam int WBS_TGA_W_DEF = 1;   // Address tag width
    localparam int WBS_TGD_W_DEF = 1;   // Data tag width (single bit allowed)
    localparam int WBS_MEM_AW_DEF = 8;  // Word index width of the store
    localparam int WBS_WAIT_W = 4;      // Width of the wait-state count

    // Reset values
    localparam logic [WBS_WAIT_W-1:0] WBS_CNT_RST = 4'h0;  // Wait counter after reset

    // Controller states, one-hot
    typedef enum logic [2:0] {
        WBS_IDLE = 3'b001,  // Waiting for a strobe
        WBS_WAIT = 3'b010,  // Inserting slave wait states
        WBS_TERM = 3'b100   // Driving one termination
    } wbs_state_t;

    // Cycle termination group, at most one bit set
    typedef struct packed {
        logic rty;  // Retry later
        logic err;  // Error
        logic ack;  // Normal end
    } wbs_term_t;

    // Cycle-class tag: single, block or read-modify-write
    typedef struct packed {
        logic rmw;  // Read-modify-write cycle
        logic blk;  // Block cycle
        logic sgl;  // Single cycle
    } wbs_tgc_t;

endpackage : wbs_pkg

/* File: hw/wbs_mem.sv */
// Word store with byte-lane writes and a registered read port.
// Assumes the caller gates enables with its clock enable.
`timescale 1ns/1ps
module wbs_mem #(
    parameter int AW = 8,   // Word index width
    parameter int NB = 2,   // Byte lanes
    parameter int TW = 1    // Tag bits kept with each word
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [NB-1:0]     wr_sel,
    input  wire logic [AW-1:0]     wr_adr,
    input  wire logic [NB*8-1:0]   wr_dat,
    input  wire logic [TW-1:0]     wr_tag,
    // Read port
    input  wire logic              rd_en,
    input  wire logic [AW-1:0]     rd_adr,
    output logic      [NB*8-1:0]   rd_dat,
    output logic      [TW-1:0]     rd_tag
);

    logic [TW-1:0]   mem_tag [2**AW];  // Tags stored with the words

    // Each lane owns its bytes and read register, so no two processes share one
    for (genvar b = 0; b < NB; b++) begin : g_lane
        logic [7:0] lane_mem [2**AW];  // Bytes of this lane
        logic [7:0] lane_rd_q;         // Read byte held until the next read

        // Lane write when its select is set
        always_ff @(posedge core_clk) begin
            if (wr_en && wr_sel[b]) begin
                lane_mem[wr_adr] <= wr_dat[b*8 +: 8];
            end
        end

        // Lane read register
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                lane_rd_q <= 8'h00;
            end else if (rd_en) begin
                lane_rd_q <= lane_mem[rd_adr];
            end
        end

        // Lane byte onto the read bus
        assign rd_dat[b*8 +: 8] = lane_rd_q;
    end

    // Tag follows any write to the word
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_tag[wr_adr] <= wr_tag;
        end
    end

    // Read tag held in a register until the next read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_tag <= '0;
        end else if (rd_en) begin
            rd_tag <= mem_tag[rd_adr];
        end
    end

endmodule // wbs_mem

/* File: hw/wbs_slave.sv */
// Bus slave for single and block cycles, standard or pipelined handshake,
// backed by a small word store with read and write data tags.
// Assumes master and slave share core_clk and that all inputs are
// synchronous to it; rst_i is the bus reset, arst_n the power-on reset.
//
// Overview of operation
// [RL1] Read data meaningful only during termination
// [RL2] Tags travel with address, data, cycle
// [RL3] Each tag valid exactly with its companion
// [RL4] Tags may be single bits
// [RL5] Master marks single, block, RMW cycles
// [RL6] Master parity tag: even ones asserted
// [RL7] Master starts read with all signals together
// [RL8] Read acknowledge only for active strobe
// [RL9] Slave wait states; master holds request
// [RL10] Standard: master ends cycle after acknowledge
// [RL11] Pipelined: strobe one cycle, cycle until acknowledge
// [RL12] Master starts write with all signals together
// [RL13] Write data taken at acknowledged edge
// [RL14] Block cycle keeps cycle line high
// [RL15] Lock held to keep arbitration
// [RL16] Supported cycles obey their timing
// [RL17] Standard terminations from cycle AND strobe
// [RL18] Never two terminations at once
// [RL19] Pipelined master accepts acknowledge anytime
// [RL20] Bus reset holds terminations low
`timescale 1ns/1ps
module wbs_slave
    import wbs_pkg::*;
#(
    parameter int ADR_W  = wbs_pkg::WBS_ADR_W_DEF,   // Address width
    parameter int DAT_W  = wbs_pkg::WBS_DAT_W_DEF,   // Data width, multiple of 8
    parameter int TGA_W  = wbs_pkg::WBS_TGA_W_DEF,   // Address tag width
    parameter int TGD_W  = wbs_pkg::WBS_TGD_W_DEF,   // Data tag width
    parameter int MEM_AW = wbs_pkg::WBS_MEM_AW_DEF,  // Store word index width
    parameter logic [TGA_W-1:0] TGA_MATCH = '0       // Address tag the store answers
) (
    // Clock, resets and enable
    input  wire logic                        core_clk,
    input  wire logic                        arst_n,
    input  wire logic                        ce,
    input  wire logic                        rst_i,
    // Request from master
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic                        lock_i,
    input  wire logic [ADR_W-1:0]            adr_i,
    input  wire logic [TGA_W-1:0]            tga_i,
    input  wire logic [DAT_W-1:0]            dat_i,
    input  wire logic [TGD_W-1:0]            tgd_i,
    input  wire logic [DAT_W/8-1:0]          sel_i,
    input  wire wbs_pkg::wbs_tgc_t           tgc_i,
    // Answer to master
    output logic                             ack_o,
    output logic                             err_o,
    output logic                             rty_o,
    output logic                             stall_o,
    output logic      [DAT_W-1:0]            dat_o,
    output logic      [TGD_W-1:0]            tgd_o,
    // Configuration and status
    input  wire logic                        pipe_mode,
    input  wire logic                        blk_en,
    input  wire logic                        busy_i,
    input  wire logic [wbs_pkg::WBS_WAIT_W-1:0] wait_states,
    output logic                             locked_o
);

    import wbs_pkg::*;

    localparam int SEL_W = DAT_W / 8;  // Byte lanes

    // Whole controller state in one record
    typedef struct packed {
        wbs_state_t            state;   // Controller state
        logic [WBS_WAIT_W-1:0] cnt;     // Wait states still to insert
        logic [MEM_AW-1:0]     adr;     // Word index taken with the request
        logic [DAT_W-1:0]      dat;     // Write data taken with the request
        logic [TGD_W-1:0]      tgd;     // Write data tag taken with the data
        logic [SEL_W-1:0]      sel;     // Byte selects
        logic                  we;      // Write request
        logic                  pipe;    // Handshake form frozen for this request
        logic                  fault;   // Request must end in error
        wbs_term_t             term;    // Termination being driven
        logic                  locked;  // Master holds the lock
    } wbs_ctx_t;

    localparam wbs_ctx_t CTX_RST = '{
        state:   WBS_IDLE,
        cnt:     WBS_CNT_RST,
        default: '0
    };

    wbs_ctx_t s_q;          // Registered state
    wbs_ctx_t s_d;          // Next state
    logic     req_go;       // Strobe presented while idle
    logic     abort;        // Master withdrew the request
    logic     adr_bad;      // Address outside store or wrong address tag
    logic     cyc_bad;      // Cycle class not supported
    logic     term_live;    // Termination may reach the bus this cycle
    logic     mem_rd;       // Fetch word for a read answer
    logic     mem_wr;       // Commit write at acknowledged edge

    // Request decode and fault checks on the live bus
    always_comb begin
        req_go  = cyc_i & stb_i;
        abort   = ~cyc_i | (~s_q.pipe & ~stb_i);                  // [RL9]
        adr_bad = (|adr_i[ADR_W-1:MEM_AW]) | (tga_i != TGA_MATCH); // [RL2] [RL3]
        cyc_bad = tgc_i.rmw | (tgc_i.blk & ~blk_en);               // [RL5] [RL16]
    end

    // Next-state logic of the whole controller
    always_comb begin
        s_d    = s_q;
        mem_rd = 1'b0;
        unique case (s_q.state)
            WBS_IDLE: begin
                // Address, data, tags and selects all taken in one cycle
                if (req_go) begin                                  // [RL3]
                    s_d.adr   = adr_i[MEM_AW-1:0];
                    s_d.dat   = dat_i;
                    s_d.tgd   = tgd_i;                             // [RL2]
                    s_d.sel   = sel_i;
                    s_d.we    = we_i;
                    s_d.pipe  = pipe_mode;
                    s_d.fault = adr_bad | cyc_bad;
                    s_d.cnt   = wait_states;
                    s_d.state = WBS_WAIT;
                end
            end
            WBS_WAIT: begin
                if (!s_q.pipe && abort) begin
                    // Standard master dropped strobe or cycle early
                    s_d.state = WBS_IDLE;
                end else if (!cyc_i) begin
                    // Pipelined master gave up the cycle
                    s_d.state = WBS_IDLE;
                end else if (s_q.cnt != WBS_CNT_RST) begin
                    // Wait states stretch the cycle
                    s_d.cnt = s_q.cnt - 1'b1;                      // [RL9]
                end else begin
                    // Exactly one termination chosen, error first
                    s_d.term = '0;                                 // [RL18]
                    if (s_q.fault) begin
                        s_d.term.err = 1'b1;
                    end else if (busy_i) begin
                        s_d.term.rty = 1'b1;
                    end else begin
                        s_d.term.ack = 1'b1;
                        mem_rd       = ~s_q.we;                    // [RL8]
                    end
                    s_d.state = WBS_TERM;
                end
            end
            WBS_TERM: begin
                // Termination lasts one cycle, then the slave is free
                s_d.term  = '0;                                    // [RL10] [RL11]
                s_d.state = WBS_IDLE;
            end
            default: begin
                // Illegal one-hot code recovers to idle
                s_d = CTX_RST;
            end
        endcase
        s_d.locked = cyc_i & lock_i;                               // [RL15] [RL14]
        if (rst_i) begin
            // Bus reset clears any cycle in progress
            s_d = CTX_RST;                                         // [RL20]
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= CTX_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Standard form needs cycle AND strobe; pipelined form needs cycle only
    always_comb begin
        term_live = (s_q.state == WBS_TERM) & cyc_i & ~rst_i       // [RL20]
                  & (s_q.pipe | stb_i);                            // [RL17] [RL19]
    end

    // Terminations are gated copies of the one-hot term record
    always_comb begin
        ack_o = s_q.term.ack & term_live;                          // [RL8] [RL18]
        err_o = s_q.term.err & term_live;                          // [RL18]
        rty_o = s_q.term.rty & term_live;                          // [RL18]
    end

    // Pipelined slave holds off new requests while one is open
    always_comb begin
        stall_o = s_q.pipe & (s_q.state != WBS_IDLE) & ~rst_i;     // [RL11]
    end

    // Write committed on the edge at which the acknowledge is sampled
    always_comb begin
        mem_wr = ce & ack_o & s_q.we;                              // [RL13]
    end

    // Status output from the state register
    always_comb begin
        locked_o = s_q.locked;
    end

    // Store; read word and tag land in its output register for the answer
    wbs_mem #(
        .AW (MEM_AW),
        .NB (SEL_W),
        .TW (TGD_W)
    ) u_mem (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wr_en    (mem_wr),
        .wr_sel   (s_q.sel),
        .wr_adr   (s_q.adr),
        .wr_dat   (s_q.dat),
        .wr_tag   (s_q.tgd),                                       // [RL13] [RL4]
        .rd_en    (mem_rd & ce & ~rst_i),
        .rd_adr   (s_q.adr),
        .rd_dat   (dat_o),                                         // [RL1]
        .rd_tag   (tgd_o)                                          // [RL1] [RL2]
    );

endmodule // wbs_slave

/* File: bench/wbs_monitor.sv */
// Port checker of the bus slave handshake.
// Assumes one clock; bound to every slave instance by port name.
`timescale 1ns/1ps
module wbs_monitor
    import wbs_pkg::*;
(
    // Clock and resets
    input wire logic                  core_clk,
    input wire logic                  arst_n,
    input wire logic                  rst_i,
    // Request side
    input wire logic                  cyc_i,
    input wire logic                  stb_i,
    input wire logic                  lock_i,
    input wire logic                  pipe_mode,
    input wire logic [WBS_WAIT_W-1:0] wait_states,
    // Answer side
    input wire logic                  ack_o,
    input wire logic                  err_o,
    input wire logic                  rty_o,
    input wire logic                  stall_o,
    input wire logic                  locked_o
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire term = ack_o | err_o | rty_o;  // Any termination
    // Fresh standard request seen from idle
    sequence s_req;
        $rose(stb_i) && cyc_i && !pipe_mode && !rst_i;
    endsequence
    // Same request without slave wait states
    sequence s_fast;
        s_req ##0 (wait_states == 4'h0);
    endsequence
    // Pipelined request from idle
    sequence s_acc_p;
        $rose(stb_i) && cyc_i && !stall_o && !rst_i;
    endsequence
    AST_ONE_TERM: assert property ($onehot0({ack_o, err_o, rty_o}))
        else $error("two terminations at once");
    AST_RST_QUIET: assert property (rst_i |-> !term && !stall_o)
        else $error("answer during bus reset");
    AST_TERM_CYC: assert property (term |-> cyc_i)
        else $error("termination without cycle");
    AST_STD_STB: assert property (!pipe_mode && term |-> stb_i)
        else $error("standard termination without strobe");
    AST_TERM_PULSE: assert property (term |=> !term)
        else $error("termination longer than one cycle");
    AST_FAST_LAT: assert property (s_fast |-> ##1 !term ##1 term)
        else $error("termination not two cycles after request");
    AST_RANGE_LAT: assert property (s_req |-> ##[2:17] term)
        else $error("termination missing after wait states");
    AST_PIPE_STALL: assert property ((s_acc_p and pipe_mode) |=> stall_o)
        else $error("no stall after pipelined request");
    AST_PIPE_TERM: assert property (pipe_mode && term |-> stall_o)
        else $error("stall released before termination");
    AST_LOCK: assert property (locked_o == $past(cyc_i && lock_i))
        else $error("lock status does not follow lock");
endmodule // wbs_monitor

bind wbs_slave wbs_monitor mon_u (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .rst_i       (rst_i),
    .cyc_i       (cyc_i),
    .stb_i       (stb_i),
    .lock_i      (lock_i),
    .pipe_mode   (pipe_mode),
    .wait_states (wait_states),
    .ack_o       (ack_o),
    .err_o       (err_o),
    .rty_o       (rty_o),
    .stall_o     (stall_o),
    .locked_o    (locked_o)
);

/* File: bench/wbm_model.sv */
// Bus master model facing the slave's request side.
// Assumes the bench calls xfer from one process only.
`timescale 1ns/1ps
module wbm_model
    import wbs_pkg::*;
(
    // Clock
    input wire logic        core_clk,
    // Request to slave
    output logic            cyc_i,
    output logic            stb_i,
    output logic            we_i,
    output logic            lock_i,
    output logic [31:0]     adr_i,
    output logic            tga_i,
    output logic [15:0]     dat_i,
    output logic            tgd_i,
    output logic [1:0]      sel_i,
    output wbs_tgc_t        tgc_i,
    // Answer from slave
    input wire logic        ack_o,
    input wire logic        err_o,
    input wire logic        rty_o,
    input wire logic [15:0] dat_o,
    input wire logic        tgd_o
);
    initial {cyc_i, stb_i, we_i, lock_i, adr_i, tga_i, dat_i, tgd_i, sel_i, tgc_i} = '0;
    // One phase; h keeps the cycle open for a block, p asks pipelined
    task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
        input logic [1:0] s, input wbs_tgc_t c, input logic ta, p, h, l,
        output wbs_term_t t, output logic [15:0] rd, output logic rt);
        int n;
        n = 0;
        @(negedge core_clk);
        {cyc_i, stb_i, we_i, lock_i} = {2'b11, w, l};
        {adr_i, dat_i, sel_i, tgc_i, tga_i} = {a, d, s, c, ta};
        tgd_i = ~^d;  // Even parity over the word
        if (p) begin  // One request cycle only
            @(negedge core_clk);
            stb_i = 1'b0;
        end
        while (!(ack_o | err_o | rty_o) && n < 40) begin  // Wait states
            @(negedge core_clk);
            n++;
        end
        t = {rty_o, err_o, ack_o};
        rd = dat_o;
        rt = tgd_o;
        @(negedge core_clk);
        stb_i = 1'b0;
        cyc_i = h;  // End cycle, or keep it for a block
        lock_i = h & l;
        adr_i = ~adr_i;  // Released lines lose their old value
        dat_i = ~dat_i;
    endtask
endmodule // wbm_model

/* File: bench/tb.sv */
// Self-checking bench of the bus slave driven by the master model.
// Assumes package and design compiled first; ce is held high.
`timescale 1ns/1ps
module tb;
    import wbs_pkg::*;
    logic        core_clk, arst_n, rst_i, pipe_mode, blk_en, busy_i, locked_o;
    logic        cyc_i, stb_i, we_i, lock_i, tga_i, tgd_i, ack_o, err_o, rty_o;
    logic        stall_o, tgd_o, w, rt;
    logic [31:0] adr_i, lf;
    logic [15:0] dat_i, dat_o, d, rd;
    logic [15:0] ref_m [16];
    logic        ref_t [16];
    logic [3:0]  wait_states, a;
    logic [1:0]  sel_i, s;
    wbs_tgc_t    tgc_i;
    wbs_term_t   t;
    int          mismatches, n_compared;
    wbs_slave dut_u (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .ce          (1'b1),
        .rst_i       (rst_i),
        .cyc_i       (cyc_i),
        .stb_i       (stb_i),
        .we_i        (we_i),
        .lock_i      (lock_i),
        .adr_i       (adr_i),
        .tga_i       (tga_i),
        .dat_i       (dat_i),
        .tgd_i       (tgd_i),
        .sel_i       (sel_i),
        .tgc_i       (tgc_i),
        .ack_o       (ack_o),
        .err_o       (err_o),
        .rty_o       (rty_o),
        .stall_o     (stall_o),
        .dat_o       (dat_o),
        .tgd_o       (tgd_o),
        .pipe_mode   (pipe_mode),
        .blk_en      (blk_en),
        .busy_i      (busy_i),
        .wait_states (wait_states),
        .locked_o    (locked_o)
    );
    wbm_model m_u (
        .core_clk (core_clk),
        .cyc_i    (cyc_i),
        .stb_i    (stb_i),
        .we_i     (we_i),
        .lock_i   (lock_i),
        .adr_i    (adr_i),
        .tga_i    (tga_i),
        .dat_i    (dat_i),
        .tgd_i    (tgd_i),
        .sel_i    (sel_i),
        .tgc_i    (tgc_i),
        .ack_o    (ack_o),
        .err_o    (err_o),
        .rty_o    (rty_o),
        .dat_o    (dat_o),
        .tgd_o    (tgd_o)
    );
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Byte-lane merge of a write into a stored word
    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic [1:0] sl);
        return {sl[1] ? n[15:8] : o[15:8], sl[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic chk_term(string nm, logic [2:0] e, logic [2:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end
    initial begin
        {arst_n, rst_i, pipe_mode, blk_en, busy_i, wait_states} = '0;
        lf = 32'h391F;
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        // Random reads and writes, both handshakes, varied wait states
        for (int i = 0; i < 60; i++) begin
            lf = nxt(lf);
            {w, a, s, d} = {(i < 16) | lf[4], (i < 16) ? i[3:0] : lf[3:0], lf[6:5], lf[31:16]};
            if (i < 16) s = 2'h3;
            pipe_mode = lf[7];
            wait_states = (i == 30) ? 4'hF : {2'h0, lf[9:8]};
            m_u.xfer(w, {28'h0, a}, d, s, 3'h1, 1'b0, pipe_mode, 1'b0, 1'b0, t, rd, rt);
            chk_term("term", 3'h1, t);
            if (w) begin
                ref_m[a] = merge(ref_m[a], d, s);
                ref_t[a] = ~^d;
            end else begin
                chk_word("rdata", ref_m[a], rd);
                chk_word("rtag", {15'h0, ref_t[a]}, {15'h0, rt});
            end
        end
        $display("random transfers done");
        // Refused writes: busy, bad address, tag, block, rmw, err over rty
        {pipe_mode, wait_states} = '0;
        for (int k = 0; k < 6; k++) begin
            busy_i = (k == 0) || (k == 5);
            m_u.xfer(1'b1, {k == 1, 31'h0}, ~ref_m[0], 2'h3, {k > 3, k == 3, k < 3},
                     k == 2, 1'b0, 1'b0, 1'b0, t, rd, rt);
            chk_term("fault", (k == 0) ? 3'h4 : 3'h2, t);
        end
        busy_i = 1'b0;
        m_u.xfer(1'b0, 32'h0, d, 2'h3, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, t, rd, rt);
        chk_word("kept", ref_m[0], rd);
        $display("fault transfers done");
        // Locked block: write then read with the cycle held open
        blk_en = 1'b1;
        d = lf[15:0];
        m_u.xfer(1'b1, 32'h1, d, 2'h3, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1, t, rd, rt);
        chk_term("blk", 3'h1, t);
        chk_word("locked", 16'h1, {15'h0, locked_o});
        m_u.xfer(1'b0, 32'h1, d, 2'h3, 3'h2, 1'b0, 1'b0, 1'b0, 1'b1, t, rd, rt);
        chk_word("blkrd", d, rd);
        $display("block transfers done");
        // Bus reset silences the slave
        rst_i = 1'b1;
        m_u.xfer(1'b0, 32'h2, d, 2'h3, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, t, rd, rt);
        chk_term("reset", 3'h0, t);
        rst_i = 1'b0;
        $display("reset test done");
        wrap_up;
    end
endmodule // tb
